// ---- pkg/bridge_params.svh ----
/*
 Timing constants and encodings for the bridge control block.
 Assumes inclusion by bare name; a 10 MHz system clock.
*/
`ifndef BRIDGE_PARAMS_SVH
`define BRIDGE_PARAMS_SVH
`define CLK_PERIOD_NS 100
// Times in their own units, as printed
`define STANDBY_ENTRY_TIME_US 1000
`define FIXED_OFF_TIME_US 25
`define TRIP_BLANKING_TIME_US 3
`define CROSSOVER_DEAD_TIME_NS 400
`define OVERCURRENT_QUALIFY_TIME_US 2
`define RETRY_TIMEOUT_US 2000
// Cycle counts: least times round up
`define CYC_US(t) (((t) * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_NS(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STANDBY_CYCLES `CYC_US(`STANDBY_ENTRY_TIME_US)
`define OFF_CYCLES `CYC_US(`FIXED_OFF_TIME_US)
`define BLANK_CYCLES `CYC_US(`TRIP_BLANKING_TIME_US)
`define DEAD_CYCLES `CYC_NS(`CROSSOVER_DEAD_TIME_NS)
`define QUAL_CYCLES `CYC_US(`OVERCURRENT_QUALIFY_TIME_US)
`define RETRY_CYCLES `CYC_US(`RETRY_TIMEOUT_US)
// Bridge leg drive codes: {drive enable, level}
`define LEG_Z 2'h0
`define LEG_LOW 2'h2
`define LEG_HIGH 2'h3
`endif

// ---- pkg/bridge_pkg.sv ----
/*
 Types for the bridge control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package bridge_pkg;
	typedef enum logic [1:0] {CMD_COAST, CMD_FWD, CMD_REV, CMD_BRAKE} cmd_e;
	typedef enum logic [2:0] {
		PH_ON, PH_FAST, PH_DEAD, PH_SLOW
	} chop_e;
	typedef enum logic [1:0] {F_OK, F_RETRY, F_LATCH} fault_e;
	typedef logic [1:0] leg_t;
endpackage

// ---- rtl/brushed_dc_bridge_control.sv ----
/*
 Control logic of a full-bridge brushed DC motor driver: command decode,
 fixed off-time mixed-decay chopping, standby, fault handling.
 Assumes analog flags arrive asynchronously and power-up drives rst_b.
*/
`include "bridge_params.svh"
`timescale 1ns/1ps
`default_nettype none
module brushed_dc_bridge_control
	import bridge_pkg::*;
#(
	parameter bit HAS_RETRY = 1'b1, // Retry select pin present
	parameter int STANDBY_CYC = `STANDBY_CYCLES, // Standby entry count
	parameter int RETRY_CYC = `RETRY_CYCLES // Retry timeout count
) (
	input wire logic sys_clk, // 10 MHz clock
	input wire logic rst_b, // Power-up reset, active low
	input wire logic controlInputA, // Control pin a
	input wire logic controlInputB, // Control pin b
	input wire logic tripFlag, // Sense above reference
	input wire logic overcurrentFlag, // Raw overcurrent detect
	input wire logic overTempFlag, // Thermal shutdown flag
	input wire logic supplyLowFlag, // Undervoltage flag
	input wire logic zeroCurrentFlag, // Decay current near zero
	input wire logic retrySelect, // Low: retry, high/open: latch
	output logic [1:0] bridgeOutputA, // Leg a {enable, level}
	output logic [1:0] bridgeOutputB, // Leg b {enable, level}
	output logic syncRectOn, // Synchronous rectification
	output logic standbyActive, // Charge pump, regulator off
	output logic faultOutputLow, // Open-drain data, always 0
	output logic faultOutputLowOe // High while pulling low
);
	localparam int OFF_CYC = `OFF_CYCLES;
	localparam int HALF_CYC = OFF_CYC / 2;
	localparam int DEAD_CYC = `DEAD_CYCLES;
	localparam int BLANK_CYC = `BLANK_CYCLES;
	localparam int QUAL_CYC = `QUAL_CYCLES;
	// Wide enough for every counter, off-time included, at any override
	localparam int CW = $clog2(STANDBY_CYC + RETRY_CYC + OFF_CYC + 2);

	// ==============================================================
	// Input synchronisers
	logic [6:0] syncA_reg;
	logic [6:0] syncB_reg;
	logic inA, inB, trip, ocRaw, hot, supply_low_lockout, zeroI, retryGnd;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			syncA_reg <= 7'h00;
			syncB_reg <= 7'h00;
		end else begin
			syncA_reg <= {retrySelect, zeroCurrentFlag, supplyLowFlag,
				overTempFlag, overcurrentFlag, tripFlag, controlInputA};
			syncB_reg <= syncA_reg;
		end
	end
	// Flags read clear until two edges after reset
	assign inA = syncB_reg[0];
	assign trip = syncB_reg[1];
	assign ocRaw = syncB_reg[2];
	assign hot = syncB_reg[3];
	assign supply_low_lockout = syncB_reg[4];
	assign zeroI = syncB_reg[5];
	assign retryGnd = HAS_RETRY && !syncB_reg[6];
	logic inB1_reg, inB2_reg;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			inB1_reg <= 1'b0;
			inB2_reg <= 1'b0;
		end else begin
			inB1_reg <= controlInputB;
			inB2_reg <= inB1_reg;
		end
	end
	assign inB = inB2_reg;

	// ==============================================================
	// Command decode
	cmd_e cmd;
	always_comb begin
		case ({inA, inB})
			2'b10: cmd = CMD_FWD;
			2'b01: cmd = CMD_REV;
			2'b11: cmd = CMD_BRAKE;
			default: cmd = CMD_COAST;
		endcase
	end

	// ==============================================================
	// Standby timer
	logic [CW-1:0] sbyCnt_reg;
	logic standby_reg;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sbyCnt_reg <= '0;
			standby_reg <= 1'b0;
		end else if (cmd != CMD_COAST) begin
			sbyCnt_reg <= '0;
			standby_reg <= 1'b0;
		end else if (sbyCnt_reg < CW'(STANDBY_CYC)) begin
			sbyCnt_reg <= sbyCnt_reg + 1'b1;
		end else begin
			standby_reg <= 1'b1;
		end
	end
	assign standbyActive = standby_reg;

	// ==============================================================
	// Overcurrent qualification and fault handling
	logic [CW-1:0] qualCnt_reg;
	logic ocQual;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			qualCnt_reg <= '0;
		end else if (!ocRaw) begin
			qualCnt_reg <= '0;
		end else if (qualCnt_reg < CW'(QUAL_CYC)) begin
			qualCnt_reg <= qualCnt_reg + 1'b1;
		end
	end
	assign ocQual = qualCnt_reg == CW'(QUAL_CYC);

	fault_e fault_reg;
	logic [CW-1:0] retryCnt_reg;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fault_reg <= F_OK;
			retryCnt_reg <= '0;
		end else begin
			case (fault_reg)
				F_OK: begin
					retryCnt_reg <= '0;
					if (ocQual) begin
						fault_reg <= retryGnd ? F_RETRY : F_LATCH;
					end
				end
				F_RETRY: begin
					if (retryCnt_reg >= CW'(RETRY_CYC - 1)) begin
						fault_reg <= F_OK;
						retryCnt_reg <= '0;
					end else begin
						retryCnt_reg <= retryCnt_reg + 1'b1;
					end
				end
				F_LATCH: begin
					if (standby_reg) begin
						fault_reg <= F_OK;
					end
				end
				default: fault_reg <= F_OK;
			endcase
		end
	end
	logic faultOff;
	assign faultOff = fault_reg != F_OK;
	assign faultOutputLow = 1'b0;
	assign faultOutputLowOe = faultOff;

	// ==============================================================
	// Chopping: on, fast decay, dead time, slow decay
	chop_e phase_reg;
	logic [CW-1:0] phCnt_reg;
	logic drive;
	logic ocStop;
	assign ocStop = ocQual;
	assign drive = (cmd == CMD_FWD || cmd == CMD_REV) && !faultOff
		&& !hot && !supply_low_lockout && !standby_reg && !ocStop;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_reg <= PH_ON;
			phCnt_reg <= '0;
		end else if (!drive) begin
			phase_reg <= PH_ON;
			phCnt_reg <= '0;
		end else begin
			case (phase_reg)
				PH_ON: begin
					if (phCnt_reg < CW'(BLANK_CYC)) begin
						phCnt_reg <= phCnt_reg + 1'b1;
					end else if (trip) begin
						phase_reg <= PH_FAST;
						phCnt_reg <= '0;
					end
				end
				PH_FAST: begin
					if (phCnt_reg >= CW'(HALF_CYC - 1)) begin
						phase_reg <= PH_DEAD;
						phCnt_reg <= '0;
					end else begin
						phCnt_reg <= phCnt_reg + 1'b1;
					end
				end
				PH_DEAD: begin
					if (phCnt_reg >= CW'(DEAD_CYC - 1)) begin
						phase_reg <= PH_SLOW;
						phCnt_reg <= '0;
					end else begin
						phCnt_reg <= phCnt_reg + 1'b1;
					end
				end
				PH_SLOW: begin
					if (phCnt_reg >= CW'(OFF_CYC - HALF_CYC - DEAD_CYC - 1))
						begin
						phase_reg <= PH_ON;
						phCnt_reg <= '0;
					end else begin
						phCnt_reg <= phCnt_reg + 1'b1;
					end
				end
				default: phase_reg <= PH_ON;
			endcase
		end
	end

	// Zero-current seen during decay stops rectification for the rest
	logic zeroSeen_reg;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			zeroSeen_reg <= 1'b0;
		end else if (phase_reg == PH_ON || !drive) begin
			zeroSeen_reg <= 1'b0;
		end else if (zeroI) begin
			zeroSeen_reg <= 1'b1;
		end
	end

	// ==============================================================
	// Output legs, registered
	leg_t legA_next, legB_next;
	logic sr_next;
	always_comb begin
		legA_next = `LEG_Z;
		legB_next = `LEG_Z;
		sr_next = 1'b0;
		if (hot || supply_low_lockout || faultOff || standby_reg || ocStop) begin
			legA_next = `LEG_Z;
			legB_next = `LEG_Z;
		end else if (cmd == CMD_BRAKE) begin
			legA_next = `LEG_LOW;
			legB_next = `LEG_LOW;
		end else if (cmd == CMD_FWD || cmd == CMD_REV) begin
			case (phase_reg)
				PH_ON: begin
					legA_next = cmd == CMD_FWD ? `LEG_HIGH : `LEG_LOW;
					legB_next = cmd == CMD_FWD ? `LEG_LOW : `LEG_HIGH;
				end
				PH_FAST: begin
					legA_next = cmd == CMD_FWD ? `LEG_LOW : `LEG_HIGH;
					legB_next = cmd == CMD_FWD ? `LEG_HIGH : `LEG_LOW;
					sr_next = !zeroSeen_reg && !zeroI;
				end
				PH_DEAD: begin
					legA_next = `LEG_Z;
					legB_next = `LEG_Z;
				end
				PH_SLOW: begin
					legA_next = `LEG_LOW;
					legB_next = `LEG_LOW;
					sr_next = !zeroSeen_reg && !zeroI;
				end
				default: begin
					legA_next = `LEG_Z;
					legB_next = `LEG_Z;
				end
			endcase
		end
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bridgeOutputA <= `LEG_Z;
			bridgeOutputB <= `LEG_Z;
			syncRectOn <= 1'b0;
		end else begin
			bridgeOutputA <= legA_next;
			bridgeOutputB <= legB_next;
			syncRectOn <= sr_next;
		end
	end

	// ==============================================================
	// Checks
	sequence tripTaken_s;
		phase_reg == PH_ON && phCnt_reg >= CW'(BLANK_CYC) && trip && drive;
	endsequence
	fault_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ocQual && fault_reg == F_OK |=> faultOutputLowOe)
		else $error("fault pin not asserted");
	latch_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		fault_reg == F_LATCH && !standby_reg |=> fault_reg == F_LATCH)
		else $error("latched fault cleared early");
	retry_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		fault_reg == F_OK && ocQual && retryGnd |=> fault_reg == F_RETRY)
		else $error("retry not chosen");
	brake_out_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cmd == CMD_BRAKE && !hot && !supply_low_lockout && !faultOff && !standby_reg
		&& !ocStop |=> bridgeOutputA == `LEG_LOW
		&& bridgeOutputB == `LEG_LOW)
		else $error("brake outputs wrong");
	coast_out_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cmd == CMD_COAST |=> bridgeOutputA == `LEG_Z)
		else $error("coast output driven");
	hot_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		hot || supply_low_lockout |=> bridgeOutputA == `LEG_Z
		&& bridgeOutputB == `LEG_Z)
		else $error("outputs on while shut down");
	decay_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		tripTaken_s |=> phase_reg == PH_FAST)
		else $error("trip did not start decay");
	blank_ign_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		phase_reg == PH_ON && phCnt_reg < CW'(BLANK_CYC) && drive
		|=> phase_reg == PH_ON)
		else $error("trip taken during blanking");
	fast_len_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		tripTaken_s ##1 (drive throughout (##124 1'b1))
		|=> phase_reg == PH_DEAD)
		else $error("fast decay length wrong");
	sby_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		standby_reg && cmd != CMD_COAST |=> !standby_reg)
		else $error("standby not left");
endmodule
`default_nettype wire

// ---- tb/host_pwm_model.sv ----
/*
 Host model that turns a wanted bridge state into the two direction pins.
 Assumes the bench changes cmd at the falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module host_pwm_model (
	input wire logic sys_clk, // Bench clock
	input wire logic [1:0] cmd, // Wanted state, cmd_e coding
	input wire logic standbyActive, // Device asleep
	output logic controlInputA, // Pin a
	output logic controlInputB, // Pin b
	output logic wakeBusy // Charge pump still settling
);
	// ==========================================
	// Pin drive
	assign controlInputA = cmd[0];
	assign controlInputB = cmd[1];
	// ==========================================
	// Wake settling, 30 us at 10 MHz
	int settle = 0;
	logic wasAsleep = 1'b0;
	always @(posedge sys_clk) begin
		if (wasAsleep && !standbyActive)
			settle <= 300;
		else if (settle > 0)
			settle <= settle - 1;
		wasAsleep <= standbyActive;
	end
	assign wakeBusy = (settle != 0);
endmodule
`default_nettype wire

// ---- tb/tb_brushed_dc_bridge_control.sv ----
/*
 Self-checking bench: queued expectations, a watcher that compares them.
 Assumes short standby and retry counts set through parameters.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bridge_params.svh"
module tb_brushed_dc_bridge_control
	import bridge_pkg::*;
;
	// ==========================================
	// Word: {check sync, sync, leg a, leg b, fault oe, standby}
	localparam logic [7:0] W_FWD = {2'h0, `LEG_HIGH, `LEG_LOW, 2'h0};
	localparam logic [7:0] W_REV = {2'h0, `LEG_LOW, `LEG_HIGH, 2'h0};
	localparam logic [7:0] W_BRK = {2'h0, `LEG_LOW, `LEG_LOW, 2'h0};
	localparam logic [7:0] W_Z = 8'h00;
	localparam logic [7:0] W_FLT = 8'h02;
	localparam logic [7:0] W_SBY = 8'h01;
	logic sys_clk, rst_b, tripFlag, overcurrentFlag, overTempFlag;
	logic supplyLowFlag, zeroCurrentFlag, retrySelect;
	logic controlInputA, controlInputB, wakeBusy;
	logic syncRectOn, standbyActive, faultOutputLow, faultOutputLowOe;
	logic [1:0] bridgeOutputA, bridgeOutputB;
	logic [7:0] e, s;
	logic [7:0] expQ[$];
	logic [15:0] rnd = 16'h8CDC;
	cmd_e cmd;
	int errCount = 0;
	int checked = 0;
	cmd_e cmdList[4] = '{CMD_FWD, CMD_REV, CMD_BRAKE, CMD_COAST};
	logic [7:0] cmdWord[4] = '{W_FWD, W_REV, W_BRK, W_Z};

	brushed_dc_bridge_control #(
		.HAS_RETRY(1'b1),
		.STANDBY_CYC(50),
		.RETRY_CYC(40)
	) i_brushed_dc_bridge_control (
		.sys_clk(sys_clk), .rst_b(rst_b),
		.controlInputA(controlInputA), .controlInputB(controlInputB),
		.tripFlag(tripFlag), .overcurrentFlag(overcurrentFlag),
		.overTempFlag(overTempFlag), .supplyLowFlag(supplyLowFlag),
		.zeroCurrentFlag(zeroCurrentFlag), .retrySelect(retrySelect),
		.bridgeOutputA(bridgeOutputA), .bridgeOutputB(bridgeOutputB),
		.syncRectOn(syncRectOn), .standbyActive(standbyActive),
		.faultOutputLow(faultOutputLow), .faultOutputLowOe(faultOutputLowOe)
	);
	host_pwm_model i_host_pwm_model (
		.sys_clk(sys_clk), .cmd(cmd), .standbyActive(standbyActive),
		.controlInputA(controlInputA), .controlInputB(controlInputB),
		.wakeBusy(wakeBusy)
	);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// ==========================================
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			errCount++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", checked, errCount);
		if (errCount == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic note(input logic [7:0] w);
		expQ.push_back(w);
		@(negedge sys_clk);
	endtask
	// Never issue a command while the charge pump settles
	task automatic go(input cmd_e c);
		int n;
		n = 0;
		while (wakeBusy === 1'b1 && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 400) begin
			errCount++;
			tally_and_finish();
		end
		cmd = c;
	endtask

	// ==========================================
	// Watcher: settled outputs against the oldest note
	always @(negedge sys_clk) begin
		#10;
		if (expQ.size() > 0) begin
			e = expQ.pop_front();
			s = {e[7], e[7] & syncRectOn, bridgeOutputA, bridgeOutputB,
				faultOutputLowOe, standbyActive};
			check(s, e);
			check({7'h00, faultOutputLow}, 8'h00);
		end
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		errCount++;
		tally_and_finish();
	end

	// ==========================================
	// Main sequence
	initial begin
		cmd = CMD_COAST;
		rst_b = 1'b0;
		{tripFlag, overcurrentFlag, overTempFlag} = 3'h0;
		{supplyLowFlag, zeroCurrentFlag} = 2'h0;
		retrySelect = 1'b1;
		cyc(3);
		note(W_Z);
		rst_b = 1'b1;
		foreach (cmdList[i]) begin
			go(cmdList[i]);
			cyc(5);
			note(cmdWord[i]);
		end
		go(CMD_BRAKE);
		cyc(40);
		note(W_BRK);
		// Coast gaps below the standby count restart the timer
		repeat (3) begin
			rnd = lfsr(rnd);
			go(CMD_COAST);
			cyc(10 + int'(rnd[4:0]));
			go(CMD_FWD);
			cyc(2);
		end
		go(CMD_COAST);
		cyc(20);
		note(W_Z);
		cyc(40);
		note(W_SBY);
		go(CMD_FWD);
		cyc(10);
		go(CMD_FWD);
		cyc(40);
		// Chop forward: fast, slow, zero current, then redrive
		tripFlag = 1'b1;
		cyc(60);
		note({2'h3, `LEG_LOW, `LEG_HIGH, 2'h0});
		cyc(140);
		note({2'h3, `LEG_LOW, `LEG_LOW, 2'h0});
		zeroCurrentFlag = 1'b1;
		cyc(5);
		note({2'h2, `LEG_LOW, `LEG_LOW, 2'h0});
		{tripFlag, zeroCurrentFlag} = 2'h0;
		cyc(80);
		note(W_FWD);
		go(CMD_REV);
		cyc(10);
		tripFlag = 1'b1;
		cyc(60);
		note({2'h3, `LEG_HIGH, `LEG_LOW, 2'h0});
		tripFlag = 1'b0;
		go(CMD_FWD);
		cyc(300);
		// Short overcurrent is ignored, long one latches
		overcurrentFlag = 1'b1;
		cyc(10);
		overcurrentFlag = 1'b0;
		cyc(5);
		note(W_FWD);
		overcurrentFlag = 1'b1;
		cyc(30);
		note(W_FLT);
		overcurrentFlag = 1'b0;
		cyc(60);
		note(W_FLT);
		go(CMD_COAST);
		cyc(60);
		note(W_SBY);
		go(CMD_FWD);
		cyc(5);
		retrySelect = 1'b0;
		go(CMD_FWD);
		cyc(10);
		overcurrentFlag = 1'b1;
		cyc(30);
		overcurrentFlag = 1'b0;
		note(W_FLT);
		cyc(60);
		note(W_FWD);
		overTempFlag = 1'b1;
		cyc(5);
		note(W_Z);
		overTempFlag = 1'b0;
		cyc(5);
		note(W_FWD);
		supplyLowFlag = 1'b1;
		cyc(5);
		note(W_Z);
		supplyLowFlag = 1'b0;
		cyc(5);
		note(W_FWD);
		tally_and_finish();
	end
endmodule
`default_nettype wire
